/* shared/vtc_pkg.sv */
// Constants, carrier structs and state types of the transceiver mode controller.
// Assumes a single 25 MHz clock and an AHB-Lite register bus.
package vtc_pkg;

  localparam logic [31:0] CLK_HZ = 32'd25_000_000;
  localparam logic [31:0] TX_TIMEOUT_S = 32'd120;
  localparam logic [31:0] LONG_PRESS_S = 32'd2;
  localparam logic [31:0] TX_TIMEOUT_CYC = TX_TIMEOUT_S * CLK_HZ;
  localparam logic [31:0] LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;

  localparam int FREQ_W = 12;
  localparam logic [11:0] FREQ_MAX = 12'h8E7;
  localparam logic [11:0] STEP_MHZ = 12'h078;
  localparam logic [11:0] STEP_100K = 12'h00C;
  localparam logic [11:0] STEP_FINE_833 = 12'h001;
  localparam logic [11:0] STEP_FINE_25 = 12'h003;
  localparam int USER_SLOTS = 99;
  localparam int RECENT_SLOTS = 9;
  localparam int ALL_SLOTS = USER_SLOTS + RECENT_SLOTS;
  localparam int LABEL_W = 80;
  localparam logic [6:0] FIRST_RECENT = 7'h63;
  localparam logic [6:0] LAST_SLOT = 7'h6B;

  localparam logic [3:0] IDX_CONFIG = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_ACTIVE = 4'h2;
  localparam logic [3:0] IDX_PRESET = 4'h3;
  localparam logic [3:0] IDX_SLOT_SEL = 4'h4;
  localparam logic [3:0] IDX_SLOT_FREQ = 4'h5;
  localparam logic [3:0] IDX_LABEL0 = 4'h6;
  localparam logic [3:0] IDX_LABEL1 = 4'h7;
  localparam logic [3:0] IDX_LABEL2 = 4'h8;
  localparam logic [3:0] IDX_CURSOR = 4'h9;

  localparam int CFG_DUAL = 0;
  localparam int CFG_STD_EN = 1;
  localparam int CFG_DIR_EN = 2;
  localparam int CFG_CHAN_EN = 3;
  localparam int CFG_RECENT_EN = 4;
  localparam int CFG_STORE_EN = 5;
  localparam int CFG_SPACE25 = 6;
  localparam int CFG_HP_EN = 7;
  localparam int CFG_SPK_EN = 8;
  localparam int CFG_IC_EN = 9;
  localparam int CFG_W = 10;
  localparam logic [9:0] CFG_RESET = 10'h3BE;
  localparam logic [9:0] CFG_LOCKED_TX = 10'h04E;

  localparam int ST_TX = 0;
  localparam int ST_MIC1 = 1;
  localparam int ST_MIC2 = 2;
  localparam int ST_MODE = 3;
  localparam int ST_SCAN = 5;
  localparam int ST_STUCK = 6;
  localparam int ST_GROUP = 7;
  localparam int ST_LOCK = 9;
  localparam int SLOT_VALID = 12;

  localparam int PIN_TALK1 = 0;
  localparam int PIN_TALK2 = 1;
  localparam int PIN_KEY0 = 2;
  localparam int PIN_ENC_A = 6;
  localparam int PIN_ENC_B = 7;
  localparam int KEY_SEL = 0;
  localparam int KEY_SWAP = 1;
  localparam int KEY_SAVE = 2;
  localparam int KEY_PUSH = 3;
  localparam logic [7:0] PIN_IDLE = 8'h03;

  typedef enum logic [1:0] {MODE_STD, MODE_DIRECT, MODE_CHAN} vtc_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_ON, TX_LOCK} vtc_tx_t;
  typedef enum logic [1:0] {GRP_NONE, GRP_MHZ, GRP_100K, GRP_FINE} vtc_group_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } vtc_ahb_in_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } vtc_ahb_out_t;

  typedef struct packed {
    logic encoder_b;
    logic encoder_a;
    logic encoder_push;
    logic memory_save_key;
    logic swap_scan_key;
    logic selection_cycle_key;
    logic talk_key_two_n;
    logic talk_key_one_n;
  } vtc_panel_t;

  typedef struct packed {
    logic hp_rx;
    logic hp_intercom;
    logic hp_aux;
    logic hp_sidetone;
    logic spk_on;
    logic spk_rx;
    logic spk_aux;
    logic mic1_on;
    logic mic2_on;
    logic intercom_on;
  } vtc_audio_t;

  typedef struct packed {
    logic [7:0][2:0] sync;
    logic [7:0] lvl;
    logic [3:0][31:0] hold_cnt;
    logic [3:0] long_done;
    vtc_tx_t tx;
    logic [31:0] tx_cnt;
    logic stuck;
    vtc_mode_t mode;
    logic scan;
    vtc_group_t grp;
    logic [11:0] act;
    logic [11:0] pre;
    logic [6:0] cursor;
    logic [6:0] slot_sel;
    logic [98:0] user_valid;
    logic [8:0][12:0] recent;
    logic [9:0] cfg;
    vtc_audio_t audio;
    logic dp_wr;
    logic [3:0] dp_idx;
    logic [31:0] rdata;
  } vtc_state_t;

endpackage

/* rtl/vtc_mode_control.sv */
// Receive/transmit switching, audio routing and frequency selection control.
// Assumes the panel pins are asynchronous and the AHB-Lite bus runs on hclk.
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps

module vtc_mode_control #(
  parameter logic [31:0] TX_TIMEOUT = vtc_pkg::TX_TIMEOUT_CYC,
  parameter logic [31:0] LONG_PRESS = vtc_pkg::LONG_PRESS_CYC
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus.
  input wire vtc_pkg::vtc_ahb_in_t ahb_in,
  output vtc_pkg::vtc_ahb_out_t ahb_out,
  // Front panel and talk keys.
  input wire vtc_pkg::vtc_panel_t panel,
  // Radio side.
  output vtc_pkg::vtc_audio_t audio,
  output logic tx_active,
  output logic stuck_talk_alarm,
  output logic [11:0] active_freq,
  output logic [11:0] preset_freq
);
  import vtc_pkg::*;

  vtc_state_t s_reg;
  vtc_state_t s_next;
  logic [11:0] user_freq [USER_SLOTS];
  logic [LABEL_W-1:0] label_mem [ALL_SLOTS];
  logic freq_we;
  logic [6:0] freq_widx;
  logic label_we;
  logic [1:0] label_part;

  function automatic logic [11:0] step_freq(input logic [11:0] f, input logic [11:0] st,
                                            input logic up);
    logic [12:0] sum;
    sum = {1'b0, f} + {1'b0, st};
    if (up) begin
      step_freq = (sum > {1'b0, FREQ_MAX}) ? FREQ_MAX : sum[11:0];
    end else begin
      step_freq = (f < st) ? 12'h000 : f - st;
    end
  endfunction

  function automatic vtc_mode_t next_mode(input vtc_mode_t m, input logic [9:0] cfg);
    logic [2:0] en;
    logic [1:0] k;
    en = {cfg[CFG_CHAN_EN], cfg[CFG_DIR_EN], cfg[CFG_STD_EN]};
    next_mode = m;
    for (int i = 3; i >= 1; i--) begin
      k = 2'((int'(m) + i) % 3);
      if (en[k]) begin
        next_mode = vtc_mode_t'(k);
      end
    end
  endfunction

  always_comb begin
    vtc_state_t n;
    logic [7:0] pins;
    logic [7:0] nl;
    logic [3:0] short_ev;
    logic [3:0] long_ev;
    logic talk1;
    logic talk2;
    logic any_talk;
    logic txing;
    logic rot;
    logic rot_up;
    logic [11:0] st;
    logic [12:0] cand;
    logic cand_ok;
    logic [6:0] vacant;
    logic have_vacant;
    logic [LABEL_W-1:0] lbl;
    logic [31:0] rd;
    logic ap;
    logic addr_ok;
    n = s_reg;
    pins = panel;
    short_ev = '0;
    long_ev = '0;
    freq_we = 1'b0;
    freq_widx = '0;
    label_we = 1'b0;
    label_part = '0;
    cand = '0;
    cand_ok = 1'b0;
    vacant = '0;
    have_vacant = 1'b0;
    rd = '0;
    nl = '0;
    rot = 1'b0;
    rot_up = 1'b0;
    talk1 = 1'b0;
    talk2 = 1'b0;
    any_talk = 1'b0;
    txing = 1'b0;
    st = '0;
    lbl = '0;
    ap = 1'b0;
    addr_ok = 1'b0;
    for (int i = 0; i < 8; i++) begin
      n.sync[i] = {s_reg.sync[i][1:0], pins[i]};
      nl[i] = (s_reg.sync[i][1] == s_reg.sync[i][2]) ? s_reg.sync[i][2] : s_reg.lvl[i];
    end
    n.lvl = nl;
    // Press timing classifies each key on release or at the hold threshold.
    for (int k = 0; k < 4; k++) begin
      if (nl[PIN_KEY0 + k]) begin
        if (s_reg.hold_cnt[k] != LONG_PRESS) begin
          n.hold_cnt[k] = s_reg.hold_cnt[k] + 32'd1;
        end
        if (s_reg.hold_cnt[k] == LONG_PRESS - 32'd1 && !s_reg.long_done[k]) begin
          long_ev[k] = 1'b1;
          n.long_done[k] = 1'b1;
        end
      end else begin
        if (s_reg.lvl[PIN_KEY0 + k] && !s_reg.long_done[k]) begin
          short_ev[k] = 1'b1;
        end
        n.hold_cnt[k] = '0;
        n.long_done[k] = 1'b0;
      end
    end
    rot = nl[PIN_ENC_A] && !s_reg.lvl[PIN_ENC_A];
    rot_up = !nl[PIN_ENC_B];
    talk1 = !nl[PIN_TALK1];
    talk2 = !nl[PIN_TALK2];
    any_talk = talk1 || talk2;
    case (s_reg.tx)
      TX_IDLE: begin
        if (any_talk) begin
          n.tx = TX_ON;
          n.tx_cnt = '0;
        end
      end
      TX_ON: begin
        if (!any_talk) begin
          n.tx = TX_IDLE;
        end else if (s_reg.tx_cnt == TX_TIMEOUT - 32'd1) begin
          n.tx = TX_LOCK;
          n.stuck = 1'b1;
        end else begin
          n.tx_cnt = s_reg.tx_cnt + 32'd1;
        end
      end
      TX_LOCK: begin
        if (!any_talk) begin
          n.tx = TX_IDLE;
        end
      end
      default: n.tx = TX_IDLE;
    endcase
    txing = (s_reg.tx == TX_ON);
    // Selection key: leaves scan, else steps to the next enabled mode.
    if (short_ev[KEY_SEL] && !txing) begin
      n.grp = GRP_NONE;
      if (s_reg.scan) begin
        n.scan = 1'b0;
      end else begin
        n.mode = next_mode(s_reg.mode, s_reg.cfg);
      end
    end
    if (long_ev[KEY_SWAP] && !txing) begin
      if (s_reg.scan) begin
        n.scan = 1'b0;
      end else if (s_reg.cfg[CFG_STD_EN]) begin
        n.scan = 1'b1;
        n.mode = MODE_STD;
        n.grp = GRP_NONE;
      end
    end
    if (short_ev[KEY_SWAP] && !txing && s_reg.mode == MODE_STD) begin
      n.act = s_reg.pre;
      n.pre = s_reg.act;
    end
    if (short_ev[KEY_PUSH] && s_reg.mode != MODE_CHAN) begin
      case (s_reg.grp)
        GRP_MHZ: n.grp = GRP_100K;
        GRP_100K: n.grp = GRP_FINE;
        default: n.grp = GRP_MHZ;
      endcase
    end
    case (s_reg.grp)
      GRP_MHZ: st = STEP_MHZ;
      GRP_100K: st = STEP_100K;
      default: st = s_reg.cfg[CFG_SPACE25] ? STEP_FINE_25 : STEP_FINE_833;
    endcase
    if (rot && s_reg.grp != GRP_NONE) begin
      if (s_reg.mode == MODE_STD) begin
        n.pre = step_freq(s_reg.pre, st, rot_up);
      end else if (s_reg.mode == MODE_DIRECT && !txing) begin
        n.act = step_freq(s_reg.act, st, rot_up);
      end
    end
    // Channel mode: the cursor steps up or down through user and recent slots, wrapping at both ends.
    if (rot && s_reg.mode == MODE_CHAN) begin
      if (rot_up) begin
        n.cursor = (s_reg.cursor == LAST_SLOT) ? 7'h00 : s_reg.cursor + 7'h01;
      end else begin
        n.cursor = (s_reg.cursor == 7'h00) ? LAST_SLOT : s_reg.cursor - 7'h01;
      end
      if (n.cursor < FIRST_RECENT) begin
        cand = {s_reg.user_valid[n.cursor], user_freq[n.cursor]};
        cand_ok = s_reg.cfg[CFG_STORE_EN];
      end else begin
        cand = s_reg.recent[n.cursor - FIRST_RECENT];
        cand_ok = s_reg.cfg[CFG_RECENT_EN];
      end
      if (s_reg.cfg[CFG_SPACE25] && (cand[11:0] % STEP_FINE_25) != 12'h000) begin
        cand_ok = 1'b0;
      end
      if (cand_ok && cand[SLOT_VALID] && !txing) begin
        n.act = cand[11:0];
      end
    end
    for (int i = USER_SLOTS - 1; i >= 0; i--) begin
      if (!s_reg.user_valid[i]) begin
        vacant = 7'(i);
        have_vacant = 1'b1;
      end
    end
    if (short_ev[KEY_SAVE] && s_reg.cfg[CFG_STORE_EN] && have_vacant
        && s_reg.mode != MODE_CHAN) begin
      freq_we = 1'b1;
      freq_widx = vacant;
      n.user_valid[vacant] = 1'b1;
    end
    if (n.act != s_reg.act && s_reg.mode != MODE_CHAN && s_reg.cfg[CFG_RECENT_EN]) begin
      for (int i = RECENT_SLOTS - 1; i > 0; i--) begin
        n.recent[i] = s_reg.recent[i - 1];
      end
      n.recent[0] = {1'b1, s_reg.act};
    end
    // Bus data phase: writes land here, one cycle after the address phase.
    if (s_reg.dp_wr) begin
      case (s_reg.dp_idx)
        IDX_CONFIG: begin
          n.cfg = ahb_in.hwdata[CFG_W-1:0];
          if (txing) begin
            n.cfg = (n.cfg & ~CFG_LOCKED_TX) | (s_reg.cfg & CFG_LOCKED_TX);
          end
        end
        IDX_STATUS: begin
          if (ahb_in.hwdata[ST_STUCK] && n.tx != TX_LOCK) begin
            n.stuck = 1'b0;
          end
        end
        IDX_SLOT_SEL: n.slot_sel = (ahb_in.hwdata[6:0] > LAST_SLOT) ? LAST_SLOT
                                                                     : ahb_in.hwdata[6:0];
        IDX_LABEL0, IDX_LABEL1, IDX_LABEL2: begin
          label_we = 1'b1;
          label_part = 2'(s_reg.dp_idx - IDX_LABEL0);
        end
        default: ;
      endcase
    end
    if (s_reg.stuck && n.tx == TX_LOCK && s_reg.tx == TX_ON) begin
      n.stuck = 1'b1;
    end
    n.audio.hp_rx = n.cfg[CFG_HP_EN] && n.tx != TX_ON;
    n.audio.hp_intercom = n.cfg[CFG_HP_EN] && n.cfg[CFG_IC_EN] && n.tx != TX_ON;
    n.audio.hp_aux = n.cfg[CFG_HP_EN] && n.tx != TX_ON;
    n.audio.hp_sidetone = n.cfg[CFG_HP_EN] && n.tx == TX_ON;
    n.audio.spk_on = n.cfg[CFG_SPK_EN] && n.tx != TX_ON;
    n.audio.spk_rx = n.cfg[CFG_SPK_EN] && n.tx != TX_ON;
    n.audio.spk_aux = n.cfg[CFG_SPK_EN] && n.tx != TX_ON;
    n.audio.mic1_on = n.tx == TX_ON && (talk1 || (n.cfg[CFG_DUAL] && talk2));
    n.audio.mic2_on = n.tx == TX_ON && (talk2 || (n.cfg[CFG_DUAL] && talk1));
    n.audio.intercom_on = n.cfg[CFG_IC_EN] && n.tx != TX_ON;
    // Address phase: read data is taken from the state as it stands after this cycle.
    ap = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
    // Unmapped or misaligned addresses neither write nor read.
    addr_ok = ahb_in.haddr[31:6] == '0 && ahb_in.haddr[1:0] == 2'h0;
    n.dp_wr = ap && ahb_in.hwrite && addr_ok;
    n.dp_idx = ahb_in.haddr[5:2];
    lbl = label_mem[n.slot_sel];
    if (label_we) begin
      lbl[16*label_part +: 16] = ahb_in.hwdata[15:0];
    end
    if (addr_ok) begin
      case (ahb_in.haddr[5:2])
        IDX_CONFIG: rd[CFG_W-1:0] = n.cfg;
        IDX_STATUS: begin
          rd[ST_TX] = n.tx == TX_ON;
          rd[ST_MIC1] = n.audio.mic1_on;
          rd[ST_MIC2] = n.audio.mic2_on;
          rd[ST_MODE +: 2] = n.mode;
          rd[ST_SCAN] = n.scan;
          rd[ST_STUCK] = n.stuck;
          rd[ST_GROUP +: 2] = n.grp;
          rd[ST_LOCK] = n.tx == TX_LOCK;
        end
        IDX_ACTIVE: rd[11:0] = n.act;
        IDX_PRESET: rd[11:0] = n.pre;
        IDX_SLOT_SEL: rd[6:0] = n.slot_sel;
        IDX_SLOT_FREQ: begin
          if (n.slot_sel < FIRST_RECENT) begin
            rd[SLOT_VALID:0] = {n.user_valid[n.slot_sel], user_freq[n.slot_sel]};
            if (freq_we && freq_widx == n.slot_sel) begin
              rd[11:0] = s_reg.act;
            end
          end else begin
            rd[SLOT_VALID:0] = n.recent[n.slot_sel - FIRST_RECENT];
          end
        end
        IDX_LABEL0: rd[15:0] = lbl[15:0];
        IDX_LABEL1: rd[15:0] = lbl[31:16];
        IDX_LABEL2: rd[15:0] = lbl[47:32];
        IDX_CURSOR: rd[6:0] = n.cursor;
        default: rd = '0;
      endcase
    end
    n.rdata = (ap && !ahb_in.hwrite) ? rd : s_reg.rdata;
    s_next = n;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
      s_reg.lvl <= PIN_IDLE;
      s_reg.sync[PIN_TALK1] <= 3'h7;
      s_reg.sync[PIN_TALK2] <= 3'h7;
    end else begin
      s_reg <= s_next;
    end
  end

  // Slot memories: no reset, validity lives in the state.
  always_ff @(posedge hclk) begin
    if (freq_we) begin
      user_freq[freq_widx] <= s_reg.act;
    end
    if (label_we) begin
      label_mem[s_reg.slot_sel][16*label_part +: 16] <= ahb_in.hwdata[15:0];
    end
  end

  assign ahb_out.hrdata = s_reg.rdata;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = 1'b0;
  assign audio = s_reg.audio;
  assign tx_active = (s_reg.tx == TX_ON);
  assign stuck_talk_alarm = s_reg.stuck;
  assign active_freq = s_reg.act;
  assign preset_freq = s_reg.pre;

endmodule // vtc_mode_control

/* sim/vtc_mode_control_sva.sv */
// Concurrent checks on the ports of the transceiver mode controller.
// Assumes it is bound to vtc_mode_control and shares its count parameters.
`timescale 1ns/10ps
module vtc_mode_control_sva #(
  parameter logic [31:0] TX_TIMEOUT = vtc_pkg::TX_TIMEOUT_CYC,
  parameter logic [31:0] LONG_PRESS = vtc_pkg::LONG_PRESS_CYC
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus.
  input wire vtc_pkg::vtc_ahb_in_t ahb_in,
  input wire vtc_pkg::vtc_ahb_out_t ahb_out,
  // Panel and radio side.
  input wire vtc_pkg::vtc_panel_t panel,
  input wire vtc_pkg::vtc_audio_t audio,
  input wire logic tx_active,
  input wire logic stuck_talk_alarm,
  input wire logic [11:0] active_freq,
  input wire logic [11:0] preset_freq
);
  import vtc_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] tx_run;
  // Counts the cycles of the current transmission.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_run <= 32'h0;
    end else begin
      tx_run <= tx_active ? tx_run + 32'h1 : 32'h0;
    end
  end
  a_rx_keys_idle: assert property ((panel.talk_key_one_n && panel.talk_key_two_n)[*6]
    |-> !tx_active) else $error("transmit with both talk keys idle");
  a_mic_only_tx: assert property ((audio.mic1_on || audio.mic2_on) |-> tx_active)
    else $error("microphone on outside transmit");
  a_tx_no_ic: assert property (tx_active |-> !audio.intercom_on && !audio.hp_intercom)
    else $error("intercom active in transmit");
  a_tx_spk_off: assert property (tx_active |-> !audio.spk_on && audio.hp_sidetone)
    else $error("speaker or sidetone wrong in transmit");
  a_rx_no_side: assert property (!tx_active |-> !audio.hp_sidetone)
    else $error("sidetone outside transmit");
  a_spk_rx_mix: assert property (!tx_active && audio.spk_on |-> audio.spk_rx)
    else $error("speaker lacks receive signal");
  a_act_frozen: assert property (tx_active && $past(tx_active)
    |-> active_freq == $past(active_freq)) else $error("active changed in transmit");
  a_tx_bounded: assert property (tx_run <= TX_TIMEOUT + 32'h1)
    else $error("transmission outlived its timeout");
  a_alarm_cause: assert property ($rose(stuck_talk_alarm) |-> !tx_active &&
    ($past(tx_active) || $past(tx_active, 2))) else $error("alarm without timeout");
  a_no_retx_held: assert property ($rose(stuck_talk_alarm) && !panel.talk_key_one_n
    |=> (!tx_active)[*6]) else $error("transmit resumed without release");
  a_bus_okay: assert property (ahb_out.hreadyout && !ahb_out.hresp)
    else $error("bus not ready or error response");
  c_tx_start: cover property ($rose(tx_active));
  c_alarm: cover property ($rose(stuck_talk_alarm));
  c_act_edit: cover property (!$stable(active_freq));
  c_pre_edit: cover property (!$stable(preset_freq));
endmodule // vtc_mode_control_sva

bind vtc_mode_control vtc_mode_control_sva #(.TX_TIMEOUT(TX_TIMEOUT), .LONG_PRESS(LONG_PRESS))
  sva_u (.hclk(hclk), .hresetn(hresetn), .ahb_in(ahb_in), .ahb_out(ahb_out), .panel(panel),
  .audio(audio), .tx_active(tx_active), .stuck_talk_alarm(stuck_talk_alarm),
  .active_freq(active_freq), .preset_freq(preset_freq));

/* sim/vtc_panel_model.sv */
// Model of the pilot talk keys, front-panel keys and rotary encoder.
// Assumes the bench calls its tasks right after a rising edge of hclk.
`timescale 1ns/10ps
module vtc_panel_model (
  // Clock.
  input wire logic hclk,
  // Panel pins.
  output vtc_pkg::vtc_panel_t panel
);
  import vtc_pkg::*;
  initial panel = PIN_IDLE;
  // Presses or releases one talk key; a new press follows a release.
  task automatic talk(input int which, input logic on);
    @(posedge hclk);
    panel[which] <= !on;
  endtask
  // Holds one key for a number of cycles, then lets it settle.
  task automatic key(input int k, input int cyc);
    @(posedge hclk);
    panel[PIN_KEY0 + k] <= 1'b1;
    repeat (cyc) @(posedge hclk);
    panel[PIN_KEY0 + k] <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
  // One encoder step; the direction line is set before the step edge.
  task automatic turn(input logic up);
    @(posedge hclk);
    panel.encoder_b <= !up;
    repeat (6) @(posedge hclk);
    panel.encoder_a <= 1'b1;
    repeat (6) @(posedge hclk);
    panel.encoder_a <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask
endmodule // vtc_panel_model

/* sim/vtc_mode_control_test.sv */
// Self-checking bench of the transceiver mode controller.
// Assumes the panel model and the bound checker are compiled beside it.
`timescale 1ns/10ps
module vtc_mode_control_test;
  import vtc_pkg::*;
  localparam logic [31:0] TMO = 32'd200;
  localparam logic [31:0] LNG = 32'd20;
  localparam int LIMIT = 20000;
  logic hclk;
  logic hresetn;
  vtc_ahb_in_t ahb_in;
  vtc_ahb_out_t ahb_out;
  vtc_panel_t panel;
  vtc_audio_t audio;
  logic tx_active;
  logic stuck_talk_alarm;
  logic [11:0] active_freq;
  logic [11:0] preset_freq;
  logic [31:0] rd_v;
  int n_fail;
  int cmp_count;
  int cyc;
  assign ahb_in.hready = ahb_out.hreadyout;
  vtc_mode_control #(.TX_TIMEOUT(TMO), .LONG_PRESS(LNG)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .ahb_in(ahb_in), .ahb_out(ahb_out), .panel(panel), .audio(audio),
    .tx_active(tx_active), .stuck_talk_alarm(stuck_talk_alarm),
    .active_freq(active_freq), .preset_freq(preset_freq));
  vtc_panel_model pm_u (.hclk(hclk), .panel(panel));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One single word transfer; read data lands in rd_v.
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    ahb_in.hsel <= 1'b1;
    ahb_in.haddr <= a;
    ahb_in.hwrite <= w;
    ahb_in.htrans <= 2'b10;
    ahb_in.hsize <= 3'b010;
    do @(posedge hclk); while (ahb_out.hreadyout !== 1'b1);
    ahb_in.htrans <= 2'b00;
    ahb_in.hsel <= 1'b0;
    ahb_in.hwdata <= d;
    do @(posedge hclk); while (ahb_out.hreadyout !== 1'b1);
    rd_v = ahb_out.hrdata;
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp,
    input logic [31:0] mask);
    bus(a, 1'b0, 32'h0);
    chk(what, exp, rd_v & mask);
  endtask
  task automatic t_reset;
    chk("audio", 32'h3B9, {22'h0, audio});
    chk("tx", 32'h0, {31'h0, tx_active});
    rdchk("config", 32'h00, 32'h3BE, 32'hFFFFFFFF);
    rdchk("unmapped", 32'h3C, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
  endtask
  task automatic talk_chk(input int which, input logic [31:0] mics);
    pm_u.talk(which, 1'b1);
    tick(8);
    chk("tx on", 32'h1, {31'h0, tx_active});
    chk("mics", mics, {22'h0, audio} & 32'h7);
    chk("speaker", 32'h40, {22'h0, audio} & 32'h60);
  endtask
  task automatic t_talk;
    talk_chk(PIN_TALK1, 32'h4);
    bus(32'h00, 1'b1, 32'h380);
    rdchk("locked config", 32'h00, 32'h38E, 32'hFFFFFFFF);
    pm_u.key(KEY_SEL, 8);
    rdchk("mode in tx", 32'h04, 32'h0, 32'h18);
    pm_u.talk(PIN_TALK1, 1'b0);
    tick(8);
    chk("tx off", 32'h0, {31'h0, tx_active});
    bus(32'h00, 1'b1, 32'h3BE);
    talk_chk(PIN_TALK2, 32'h2);
    pm_u.talk(PIN_TALK2, 1'b0);
    bus(32'h00, 1'b1, 32'h3BF);
    tick(8);
    talk_chk(PIN_TALK1, 32'h6);
    pm_u.talk(PIN_TALK1, 1'b0);
    bus(32'h00, 1'b1, 32'h3BE);
    tick(8);
    $display("test talk done");
  endtask
  task automatic t_timeout;
    pm_u.talk(PIN_TALK1, 1'b1);
    tick(int'(TMO) + 40);
    chk("tx after timeout", 32'h0, {31'h0, tx_active});
    chk("alarm", 32'h1, {31'h0, stuck_talk_alarm});
    tick(10);
    chk("tx held", 32'h0, {31'h0, tx_active});
    pm_u.talk(PIN_TALK1, 1'b0);
    tick(8);
    talk_chk(PIN_TALK1, 32'h4);
    pm_u.talk(PIN_TALK1, 1'b0);
    tick(8);
    bus(32'h04, 1'b1, 32'h40);
    tick(2);
    chk("alarm cleared", 32'h0, {31'h0, stuck_talk_alarm});
    $display("test timeout done");
  endtask
  task automatic t_modes;
    logic [31:0] seq [5] = '{32'h1, 32'h2, 32'h0, 32'h2, 32'h0};
    for (int i = 0; i < 5; i++) begin
      if (i == 3) begin
        bus(32'h00, 1'b1, 32'h3BA);
      end
      pm_u.key(KEY_SEL, 8);
      rdchk("mode", 32'h04, seq[i] << 3, 32'h18);
      chk("active kept", 32'h0, {20'h0, active_freq});
    end
    bus(32'h00, 1'b1, 32'h3BE);
    pm_u.key(KEY_SWAP, 30);
    rdchk("scan on", 32'h04, 32'h20, 32'h20);
    pm_u.key(KEY_SWAP, 30);
    rdchk("scan off", 32'h04, 32'h0, 32'h20);
    $display("test modes done");
  endtask
  task automatic step(input logic up, input logic [31:0] pre);
    pm_u.turn(up);
    chk("preset", pre, {20'h0, preset_freq});
    chk("active", 32'h0, {20'h0, active_freq});
  endtask
  task automatic t_edit;
    pm_u.key(KEY_PUSH, 8);
    rdchk("group", 32'h04, 32'h80, 32'h180);
    step(1'b1, 32'h078);
    pm_u.key(KEY_PUSH, 8);
    step(1'b1, 32'h084);
    pm_u.key(KEY_PUSH, 8);
    rdchk("group", 32'h04, 32'h180, 32'h180);
    step(1'b1, 32'h085);
    step(1'b0, 32'h084);
    pm_u.talk(PIN_TALK1, 1'b1);
    tick(8);
    step(1'b1, 32'h085);
    pm_u.key(KEY_SWAP, 8);
    chk("no swap in tx", 32'h0, {20'h0, active_freq});
    pm_u.talk(PIN_TALK1, 1'b0);
    tick(8);
    pm_u.key(KEY_SWAP, 8);
    chk("swapped act", 32'h085, {20'h0, active_freq});
    chk("swapped pre", 32'h0, {20'h0, preset_freq});
    bus(32'h10, 1'b1, 32'd99);
    rdchk("recent one", 32'h14, 32'h1000, 32'h1FFF);
    pm_u.key(KEY_SEL, 8);
    pm_u.key(KEY_PUSH, 8);
    pm_u.turn(1'b1);
    chk("direct", 32'h0FD, {20'h0, active_freq});
    pm_u.key(KEY_SAVE, 8);
    bus(32'h10, 1'b1, 32'h0);
    rdchk("slot one", 32'h14, 32'h10FD, 32'h1FFF);
    bus(32'h10, 1'b1, 32'h7F);
    rdchk("slot clamp", 32'h10, 32'h6B, 32'h7F);
    bus(32'h18, 1'b1, 32'h4142);
    rdchk("label", 32'h18, 32'h4142, 32'hFFFF);
    pm_u.turn(1'b0);
    chk("direct down", 32'h085, {20'h0, active_freq});
    pm_u.key(KEY_SEL, 8);
    bus(32'h00, 1'b1, 32'h3FE);
    pm_u.turn(1'b1);
    pm_u.turn(1'b0);
    chk("raster refused", 32'h085, {20'h0, active_freq});
    rdchk("cursor", 32'h24, 32'h0, 32'h7F);
    bus(32'h00, 1'b1, 32'h3BE);
    pm_u.turn(1'b1);
    pm_u.turn(1'b0);
    chk("channel tune", 32'h0FD, {20'h0, active_freq});
    $display("test edit done");
  endtask
  initial begin
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    ahb_in.hsel = 1'b0;
    ahb_in.haddr = 32'h0;
    ahb_in.htrans = 2'b00;
    ahb_in.hwrite = 1'b0;
    ahb_in.hsize = 3'b000;
    ahb_in.hwdata = 32'h0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    tick(3);
    t_reset();
    t_talk();
    t_timeout();
    t_modes();
    t_edit();
    end_of_test();
  end
endmodule // vtc_mode_control_test
